// ==== hw/imc_monitor_ctrl.sv ====
module imc_monitor_ctrl
    import imc_pkg::*;
#(
    parameter int SETTLE_CYCLES = imc_pkg::SETTLE_CYC,
    parameter int MEAS_CYCLES   = imc_pkg::MEAS_MAX_CYC
) (
    input  wire logic               CLK,
    input  wire logic               RESET,
    input  wire imc_pkg::imc_req_t  REG_REQ,
    output logic                    REG_ACK,
    output logic                    REG_ERR,
    output logic [15:0]             REG_RDATA,
    input  wire logic [15:0]        DC_VOLT,
    input  wire imc_pkg::imc_meas_t MEAS,
    output logic                    GROUND_SWITCH,
    output logic                    MEAS_RUN,
    output logic                    POS_BRIDGE_LEG_HI,
    output logic                    NEG_BRIDGE_LEG_HI
);
    import imc_pkg::*;

    initial begin
        if (SETTLE_CYCLES < 2 || SETTLE_CYCLES >= (1 << 30) || MEAS_CYCLES < 2 || MEAS_CYCLES >= (1 << 30))
            $error("imc_monitor_ctrl: counts must lie in 2 .. 2**30-1");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    imc_mode_t   mode_ff;
    logic        mon_on_ff;
    logic        settled_ff;
    logic [29:0] settle_cnt_ff;
    logic [29:0] wd_cnt_ff;
    logic        res_valid_ff;
    logic        volt_valid_ff;
    logic [15:0] res_pos_ff;
    logic [15:0] res_neg_ff;
    logic [15:0] volt_pos_ff;
    logic [15:0] volt_neg_ff;
    logic        phase_ff;
    logic        ack_ff;
    logic        err_ff;
    logic [15:0] rdata_ff;
    logic        run_ff;
    logic        pos_hi_ff;
    logic        neg_hi_ff;

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire is_auto   = (mode_ff == MODE_AUTO);
    wire wr_mode   = REG_REQ.wr && (REG_REQ.addr == OFS_MODE);
    wire wr_onoff  = REG_REQ.wr && (REG_REQ.addr == OFS_ONOFF);
    wire mode_a    = wr_mode && (REG_REQ.wdata == MODE_AUTO_VAL);
    wire mode_f    = wr_mode && (REG_REQ.wdata == MODE_FIXED_VAL);
    wire mon_set   = wr_onoff && (REG_REQ.wdata == MON_ON_VAL);
    wire mon_clr   = wr_onoff && (REG_REQ.wdata == MON_OFF_VAL);
    wire wr_bad    = REG_REQ.wr && !(mode_a || mode_f || mon_set || mon_clr);
    // dc window is judged every cycle whatever the monitoring state
    wire volt_ok   = (DC_VOLT >= DC_MIN_V) && (DC_VOLT <= DC_MAX_V);
    wire res_take  = MEAS.done && mon_on_ff && is_auto;
    wire volt_take = MEAS.done && mon_on_ff && !is_auto;
    wire settle_hit = (settle_cnt_ff == 30'(SETTLE_CYCLES - 1));
    wire wd_hit     = (wd_cnt_ff == 30'(MEAS_CYCLES - 1));

    function automatic logic [15:0] sat_res(input logic [23:0] kohm);
        if (kohm > RES_MAX_KOHM)
            sat_res = INF_CODE;
        else if (kohm < RES_MIN_KOHM)
            sat_res = RES_MIN_KOHM[15:0];
        else
            sat_res = kohm[15:0];
    endfunction : sat_res

    ////////////////////////////////////////////////////////////////////////
    // next values
    // a write that toggles monitoring never touches the mode
    imc_mode_t nxt_mode;
    always_comb begin
        case (mode_ff)
            MODE_AUTO:  nxt_mode = mode_f ? MODE_FIXED : MODE_AUTO;
            MODE_FIXED: nxt_mode = mode_a ? MODE_AUTO : MODE_FIXED;
            default:    nxt_mode = MODE_AUTO;
        endcase
    end

    wire        nxt_mon_on = mon_set ? 1'b1 : (mon_clr ? 1'b0 : mon_on_ff);
    wire        nxt_settled = mon_on_ff && (settled_ff || settle_hit);
    wire [29:0] nxt_settle_cnt = (!mon_on_ff || settled_ff) ? 30'h0 : settle_cnt_ff + 30'h1;
    wire [29:0] nxt_wd_cnt = (!run_ff || MEAS.done || wd_hit) ? 30'h0 : wd_cnt_ff + 30'h1;
    // resistance valid needs a fresh result after settling; a late result drops it
    // an off write or a write to the other mode drops validity at its own edge, so no read sees stale results
    wire nxt_res_valid = mon_on_ff && is_auto && volt_ok && settled_ff && !wd_hit
                         && !mon_clr && !mode_f
                         && (res_take || res_valid_ff);
    wire nxt_volt_valid = mon_on_ff && !mon_clr && !is_auto && !mode_a
                          && (volt_take || volt_valid_ff);
    // automatic legs swap on each finished measurement
    wire nxt_phase = is_auto ? (phase_ff ^ res_take) : 1'b0;
    wire nxt_pos_hi = !is_auto || !phase_ff;
    wire nxt_neg_hi = !is_auto || phase_ff;
    wire nxt_run = mon_on_ff && volt_ok;

    ////////////////////////////////////////////////////////////////////////
    // read mux; result and validity come from the same flops, so they agree
    wire [15:0] rd_res_pos  = res_valid_ff ? res_pos_ff : INVALID_CODE;
    wire [15:0] rd_res_neg  = res_valid_ff ? res_neg_ff : INVALID_CODE;
    wire [15:0] rd_volt_pos = volt_valid_ff ? volt_pos_ff : INVALID_CODE;
    wire [15:0] rd_volt_neg = volt_valid_ff ? volt_neg_ff : INVALID_CODE;
    wire [2:0]  mode_field  = is_auto ? ST_MODE_AUTO : ST_MODE_FIXED;
    wire [15:0] rd_status   = (16'(mode_field) << ST_MODE_LSB)
                              | (16'(mon_on_ff) << ST_MON_ON)
                              | (16'(res_valid_ff) << ST_RES_VALID);
    wire rd_hit = (REG_REQ.addr >= OFS_RES_POS) && (REG_REQ.addr <= OFS_VOLT_NEG);
    wire [15:0] nxt_rdata = (REG_REQ.addr == OFS_RES_POS)  ? rd_res_pos  :
                            (REG_REQ.addr == OFS_RES_NEG)  ? rd_res_neg  :
                            (REG_REQ.addr == OFS_STATUS)   ? rd_status   :
                            (REG_REQ.addr == OFS_VOLT_POS) ? rd_volt_pos :
                            (REG_REQ.addr == OFS_VOLT_NEG) ? rd_volt_neg : 16'h0000;
    wire nxt_err = (REG_REQ.rd && !rd_hit) || wr_bad;

    ////////////////////////////////////////////////////////////////////////
    // flops
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mode_ff       <= MODE_AUTO;
            mon_on_ff     <= 1'b0;
            settled_ff    <= 1'b0;
            settle_cnt_ff <= 30'h0;
            wd_cnt_ff     <= 30'h0;
            res_valid_ff  <= 1'b0;
            volt_valid_ff <= 1'b0;
            phase_ff      <= 1'b0;
            run_ff        <= 1'b0;
            pos_hi_ff     <= 1'b1;
            neg_hi_ff     <= 1'b0;
        end else begin
            mode_ff       <= nxt_mode;
            mon_on_ff     <= nxt_mon_on;
            settled_ff    <= nxt_settled;
            settle_cnt_ff <= nxt_settle_cnt;
            wd_cnt_ff     <= nxt_wd_cnt;
            res_valid_ff  <= nxt_res_valid;
            volt_valid_ff <= nxt_volt_valid;
            phase_ff      <= nxt_phase;
            run_ff        <= nxt_run;
            pos_hi_ff     <= nxt_pos_hi;
            neg_hi_ff     <= nxt_neg_hi;
        end
    end

    // results keep refreshing while enabled, resistance in automatic mode and voltage in fixed mode
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            res_pos_ff  <= INVALID_CODE;
            res_neg_ff  <= INVALID_CODE;
            volt_pos_ff <= INVALID_CODE;
            volt_neg_ff <= INVALID_CODE;
        end else begin
            if (res_take) begin
                res_pos_ff <= sat_res(MEAS.res_pos_kohm);
                res_neg_ff <= sat_res(MEAS.res_neg_kohm);
            end
            if (volt_take) begin
                volt_pos_ff <= MEAS.volt_pos;
                volt_neg_ff <= MEAS.volt_neg;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ack_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= 16'h0000;
        end else begin
            ack_ff   <= REG_REQ.rd || REG_REQ.wr;
            err_ff   <= nxt_err;
            rdata_ff <= REG_REQ.rd ? nxt_rdata : 16'h0000;
        end
    end

    assign REG_ACK           = ack_ff;
    assign REG_ERR           = err_ff;
    assign REG_RDATA         = rdata_ff;
    assign GROUND_SWITCH     = mon_on_ff;
    assign MEAS_RUN          = run_ff;
    assign POS_BRIDGE_LEG_HI = pos_hi_ff;
    assign NEG_BRIDGE_LEG_HI = neg_hi_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_switch_on_close: assert property (mon_set |=> GROUND_SWITCH ##1 MEAS_RUN || !$past(volt_ok))
        else $error("grounding switch not closed after enable");
    a_res_window: assert property (res_valid_ff |-> $past(volt_ok))
        else $error("resistance valid outside dc window");
    a_off_invalid: assert property (mon_clr |=> !res_valid_ff ##1 !res_valid_ff)
        else $error("resistance valid after disable");
    a_settle_wait: assert property ($rose(mon_on_ff) |-> !res_valid_ff [*8])
        else $error("resistance valid right after enable");
    a_res_saturate: assert property (res_valid_ff |-> res_pos_ff <= INF_CODE && res_neg_ff <= INF_CODE)
        else $error("resistance result beyond infinity code");
    a_status_onoff: assert property (REG_REQ.rd && REG_REQ.addr == OFS_STATUS
        |=> REG_RDATA[ST_MON_ON] == $past(mon_on_ff))
        else $error("status on bit wrong");
    a_read_answer: assert property (REG_REQ.rd |=> REG_ACK)
        else $error("read not answered");
    a_watchdog: assert property (wd_cnt_ff < 30'(MEAS_CYCLES))
        else $error("measurement watchdog overran");
    a_auto_swap: assert property (res_take && is_auto |=> ##1 POS_BRIDGE_LEG_HI != $past(POS_BRIDGE_LEG_HI, 2))
        else $error("bridge legs did not swap");
    a_auto_volt_inv: assert property (REG_REQ.rd && REG_REQ.addr == OFS_VOLT_POS && is_auto
        |=> REG_RDATA == INVALID_CODE)
        else $error("voltage readable in automatic mode");
    a_fixed_res_inv: assert property (REG_REQ.rd && REG_REQ.addr == OFS_RES_NEG && !is_auto
        |=> REG_RDATA == INVALID_CODE)
        else $error("resistance readable in fixed mode");
    a_fixed_legs: assert property (!is_auto && $stable(mode_ff) |=> POS_BRIDGE_LEG_HI && NEG_BRIDGE_LEG_HI)
        else $error("fixed bridge legs not both high");
    a_mode_keep: assert property (wr_onoff |=> $stable(mode_ff))
        else $error("monitoring write changed mode");
    a_mode_field: assert property (REG_REQ.rd && REG_REQ.addr == OFS_STATUS
        |=> REG_RDATA[10:8] == ($past(is_auto) ? ST_MODE_AUTO : ST_MODE_FIXED))
        else $error("status mode field wrong");
    a_valid_pair: assert property (res_valid_ff |-> res_pos_ff != INVALID_CODE && res_neg_ff != INVALID_CODE)
        else $error("valid bit with invalid code");

    ////////////////////////////////////////////////////////////////////////
    // further checks on outputs, mode and result flops

    a_switch_open:
        assert property (mon_clr |=> !GROUND_SWITCH)
        else $error("grounding switch not opened after disable");

    a_run_window:
        assert property (MEAS_RUN |-> $past(volt_ok) && $past(mon_on_ff))
        else $error("front end running outside dc window");

    a_off_no_valid:
        assert property (!mon_on_ff |-> !res_valid_ff)
        else $error("resistance valid while monitoring off");

    a_invalid_read:
        assert property (REG_REQ.rd && REG_REQ.addr == OFS_RES_POS && !res_valid_ff
            |=> REG_RDATA == INVALID_CODE)
        else $error("resistance read not invalid code");

    a_valid_read:
        assert property (REG_REQ.rd && REG_REQ.addr == OFS_RES_POS && res_valid_ff
            |=> REG_RDATA != INVALID_CODE)
        else $error("valid resistance read as invalid code");

    a_status_valid:
        assert property (REG_REQ.rd && REG_REQ.addr == OFS_STATUS
            |=> REG_RDATA[ST_RES_VALID] == $past(res_valid_ff))
        else $error("status valid bit wrong");

    a_res_floor:
        assert property (res_valid_ff |-> res_pos_ff >= RES_MIN_KOHM[15:0] && res_neg_ff >= RES_MIN_KOHM[15:0])
        else $error("resistance result below range floor");

    a_run_follow:
        assert property (mon_on_ff && volt_ok |=> MEAS_RUN)
        else $error("front end not running with dc in window");

    a_res_read_ok:
        assert property (REG_REQ.rd && REG_REQ.addr == OFS_RES_NEG |=> REG_ACK && !REG_ERR)
        else $error("resistance read refused");

    a_refresh_valid:
        assert property (res_take && settled_ff && volt_ok && !wd_hit && !mon_clr && !mode_f
            |=> res_valid_ff)
        else $error("fresh result did not set valid");

    a_wd_drop:
        assert property (wd_hit |=> !res_valid_ff)
        else $error("valid kept after watchdog");

    a_mode_auto_set:
        assert property (mode_a |=> is_auto)
        else $error("automatic mode not taken");

    a_mode_fixed_set:
        assert property (mode_f |=> !is_auto)
        else $error("fixed mode not taken");

    a_auto_legs:
        assert property (is_auto && $stable(mode_ff) |=> POS_BRIDGE_LEG_HI != NEG_BRIDGE_LEG_HI)
        else $error("automatic bridge legs not split");

    a_auto_vneg_inv:
        assert property (REG_REQ.rd && REG_REQ.addr == OFS_VOLT_NEG && is_auto
            |=> REG_RDATA == INVALID_CODE)
        else $error("negative voltage readable in automatic mode");

    a_fixed_rpos_inv:
        assert property (REG_REQ.rd && REG_REQ.addr == OFS_RES_POS && !is_auto
            |=> REG_RDATA == INVALID_CODE)
        else $error("positive resistance readable in fixed mode");
endmodule : imc_monitor_ctrl

// ==== pkg/imc_pkg.sv ====
package imc_pkg;
    // register indices on the link
    localparam logic [15:0] OFS_RES_POS  = 16'h0012;
    localparam logic [15:0] OFS_RES_NEG  = 16'h0013;
    localparam logic [15:0] OFS_STATUS   = 16'h0014;
    localparam logic [15:0] OFS_VOLT_POS = 16'h0015;
    localparam logic [15:0] OFS_VOLT_NEG = 16'h0016;
    localparam logic [15:0] OFS_MODE     = 16'h0100;
    localparam logic [15:0] OFS_ONOFF    = 16'h0102;
    // written values
    localparam logic [15:0] MODE_AUTO_VAL  = 16'h0004;
    localparam logic [15:0] MODE_FIXED_VAL = 16'h0000;
    localparam logic [15:0] MON_ON_VAL     = 16'h0001;
    localparam logic [15:0] MON_OFF_VAL    = 16'h0000;
    // status word layout
    localparam int          ST_RES_VALID = 1;
    localparam int          ST_MON_ON    = 2;
    localparam int          ST_MODE_LSB  = 8;
    localparam logic [2:0]  ST_MODE_AUTO  = 3'h4;
    localparam logic [2:0]  ST_MODE_FIXED = 3'h0;
    // result codes, resistance in kilo-ohm
    localparam logic [15:0] INVALID_CODE = 16'hffff;
    localparam logic [15:0] INF_CODE     = 16'hea60;
    localparam logic [23:0] RES_MAX_KOHM = 24'h002710;
    localparam logic [23:0] RES_MIN_KOHM = 24'h000001;
    // dc window in volts
    localparam logic [15:0] DC_MIN_V = 16'h0064;
    localparam logic [15:0] DC_MAX_V = 16'h03e8;
    // timing
    localparam int CLK_MHZ     = 250;
    localparam int SETTLE_MS   = 1000;
    localparam int MEAS_MAX_MS = 2500;
    localparam int SETTLE_CYC  = SETTLE_MS * 1000 * CLK_MHZ;
    localparam int MEAS_MAX_CYC = MEAS_MAX_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        MODE_FIXED = 2'b01,
        MODE_AUTO  = 2'b10
    } imc_mode_t;

    typedef struct packed {
        logic        done;
        logic [23:0] res_pos_kohm;
        logic [23:0] res_neg_kohm;
        logic [15:0] volt_pos;
        logic [15:0] volt_neg;
    } imc_meas_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } imc_req_t;
endpackage : imc_pkg

// ==== verification/imc_front_model.sv ====
module imc_front_model
    import imc_pkg::*;
#(
    parameter int PERIOD = 10
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [23:0] res_pos,
    input  wire logic [23:0] res_neg,
    input  wire logic [15:0] volt_pos,
    input  wire logic [15:0] volt_neg,
    output imc_pkg::imc_meas_t meas
);
    timeunit 1ns;
    timeprecision 100ps;
    int   cnt;
    logic fire;
    ////////////////////////////////////////////////////////////////////////////
    // one result every period while asked to run, well inside the watchdog
    assign fire = run && (cnt == PERIOD - 1);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 0;
            meas <= '0;
        end else begin
            cnt       <= (run && !fire) ? cnt + 1 : 0;
            meas.done <= fire;
            // outside the done pulse the data lines toggle, so stale values never look valid
            meas.res_pos_kohm <= fire ? res_pos : ~meas.res_pos_kohm;
            meas.res_neg_kohm <= fire ? res_neg : ~meas.res_neg_kohm;
            meas.volt_pos     <= fire ? volt_pos : ~meas.volt_pos;
            meas.volt_neg     <= fire ? volt_neg : ~meas.volt_neg;
        end
    end
endmodule : imc_front_model

// ==== verification/tb_top.sv ====
module tb_top
    import imc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SETTLE = 20;
    localparam int PER    = 10;
    logic CLK, RESET, ack, err, gsw, run, leg_p, leg_n;
    imc_req_t req;
    imc_meas_t meas;
    logic [15:0] rdata, dc, vp, vn, q;
    logic [23:0] rp, rn;
    logic [1:0] legs;
    int error_cnt, comparisons, cyc;
    ////////////////////////////////////////////////////////////////////////////
    imc_monitor_ctrl #(.SETTLE_CYCLES(SETTLE), .MEAS_CYCLES(50)) u_dut (.CLK(CLK), .RESET(RESET),
        .REG_REQ(req), .REG_ACK(ack), .REG_ERR(err), .REG_RDATA(rdata), .DC_VOLT(dc), .MEAS(meas),
        .GROUND_SWITCH(gsw), .MEAS_RUN(run), .POS_BRIDGE_LEG_HI(leg_p), .NEG_BRIDGE_LEG_HI(leg_n));
    imc_front_model #(.PERIOD(PER)) u_front (.clk(CLK), .rst(RESET), .run(run), .res_pos(rp),
        .res_neg(rn), .volt_pos(vp), .volt_neg(vn), .meas(meas));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // request held for exactly the one edge that takes it, answer sampled just after that same edge
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic e);
        @(posedge CLK); #1;
        req = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge CLK); #1;
        req = '0;
        q = rdata;
        chk("ack", 16'h0001, {15'h0, ack});
        chk("err", {15'h0, e}, {15'h0, err});
    endtask : acc
    task automatic rd(input string name, input logic [15:0] a, input logic [15:0] exp);
        acc(1'b0, a, 16'h0000, 1'b0);
        chk(name, exp, q);
    endtask : rd
    task automatic wait_done();
        int i;
        for (i = 0; i < 4 * PER && meas.done !== 1'b1; i++) begin
            @(posedge CLK); #1;
        end
        chk("done_seen", 16'h0001, {15'h0, meas.done});
        repeat (2) @(posedge CLK);
        #1;
    endtask : wait_done
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd("status", OFS_STATUS, 16'h0400);
        rd("res_pos", OFS_RES_POS, INVALID_CODE);
        rd("volt_neg", OFS_VOLT_NEG, INVALID_CODE);
        chk("gsw", 16'h0000, {15'h0, gsw});
        chk("legs", 16'h0002, {14'h0, leg_p, leg_n});
    endtask : t_reset
    task automatic t_refuse();
        acc(1'b0, 16'h0020, 16'h0000, 1'b1);
        chk("unmapped", 16'h0000, q);
        acc(1'b1, OFS_MODE, 16'h0003, 1'b1);
        acc(1'b1, OFS_RES_POS, 16'h0001, 1'b1);
        rd("status", OFS_STATUS, 16'h0400);
    endtask : t_refuse
    task automatic t_auto_on();
        acc(1'b1, OFS_ONOFF, MON_ON_VAL, 1'b0);
        chk("gsw", 16'h0001, {15'h0, gsw});
        rd("status", OFS_STATUS, 16'h0404);
        rd("res_pos", OFS_RES_POS, INVALID_CODE);
        repeat (SETTLE + 2 * PER) @(posedge CLK);
        wait_done();
        rd("status", OFS_STATUS, 16'h0406);
        rd("res_pos", OFS_RES_POS, INF_CODE);
        rd("res_neg", OFS_RES_NEG, 16'h04d2);
        rd("volt_pos", OFS_VOLT_POS, INVALID_CODE);
        legs = {leg_p, leg_n};
        chk("legs_split", 16'h0001, {15'h0, ^legs});
        wait_done();
        chk("legs_swap", {14'h0, ~legs}, {14'h0, leg_p, leg_n});
    endtask : t_auto_on
    task automatic t_dc_drop();
        dc = 16'd99;
        repeat (3) @(posedge CLK);
        #1;
        chk("run", 16'h0000, {15'h0, run});
        rd("status", OFS_STATUS, 16'h0404);
        rd("res_neg", OFS_RES_NEG, INVALID_CODE);
        rn = 24'h000000;
        dc = 16'd1000;
        wait_done();
        rd("status", OFS_STATUS, 16'h0406);
        rd("res_neg_min", OFS_RES_NEG, 16'h0001);
    endtask : t_dc_drop
    task automatic t_fixed();
        acc(1'b1, OFS_MODE, MODE_FIXED_VAL, 1'b0);
        rd("res_neg_fix", OFS_RES_NEG, INVALID_CODE);
        rd("status", OFS_STATUS, 16'h0004);
        chk("legs", 16'h0003, {14'h0, leg_p, leg_n});
        wait_done();
        rd("volt_pos", OFS_VOLT_POS, 16'h0123);
        rd("volt_neg", OFS_VOLT_NEG, 16'h0234);
        rd("res_pos", OFS_RES_POS, INVALID_CODE);
        acc(1'b1, OFS_ONOFF, MON_OFF_VAL, 1'b0);
        chk("gsw", 16'h0000, {15'h0, gsw});
        rd("status", OFS_STATUS, 16'h0000);
        rd("volt_pos", OFS_VOLT_POS, INVALID_CODE);
        acc(1'b1, OFS_MODE, MODE_AUTO_VAL, 1'b0);
        rd("status", OFS_STATUS, 16'h0400);
    endtask : t_fixed
    task automatic t_off_valid();
        acc(1'b1, OFS_ONOFF, MON_ON_VAL, 1'b0);
        repeat (SETTLE + PER) @(posedge CLK);
        wait_done();
        rd("status", OFS_STATUS, 16'h0406);
        acc(1'b1, OFS_ONOFF, MON_OFF_VAL, 1'b0);
        rd("res_pos_off", OFS_RES_POS, INVALID_CODE);
        rd("status", OFS_STATUS, 16'h0400);
    endtask : t_off_valid
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    // a hang costs one mismatch; the full run needs well under a thousand cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        RESET = 1'b1;
        req = '0;
        dc = 16'd500;
        rp = 24'h004e20;
        rn = 24'h0004d2;
        vp = 16'h0123;
        vn = 16'h0234;
        repeat (5) @(posedge CLK);
        #1 RESET = 1'b0;
        t_reset();
        t_refuse();
        t_auto_on();
        t_dc_drop();
        t_fixed();
        t_off_valid();
        wrap_up();
    end
endmodule : tb_top
